// ---- dbu_byte_if.sv ----
`default_nettype none
// ****************************************************************
// byte carrier between link receiver and update control
// ****************************************************************
interface dbu_byte_if;
    logic start;
    logic stop;
    logic byte_valid;
    logic [7:0] byte_data;
    logic ack;
    modport rx (output start, output stop, output byte_valid, output byte_data, input ack);
    modport ctl (input start, input stop, input byte_valid, input byte_data, output ack);
endinterface
`default_nettype wire

// ---- dbu_checker_sva.sv ----
`default_nettype none
// ****
// update checker
// ****
module dbu_checker
    import dbu_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_oe_o,
    input wire logic load_strobe_pin_n_i,
    input wire logic [CH_COUNT*CODE_W-1:0] dac_code_o,
    input wire logic transfer_o
);
    timeunit 1ns;
    timeprecision 10ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    reset_mid_a: assert property ($past(rst_i) |-> dac_code_o == {CH_COUNT{MIDSCALE}} && sda_oe_o)
        else $error("no midscale");
    code_move_a: assert property ($changed(dac_code_o) |-> transfer_o)
        else $error("code moved");
    quiet_hold_a: assert property ((load_strobe_pin_n_i && $stable(scl_i))[*8] |-> !transfer_o)
        else $error("stray transfer");
    pin_load_a: assert property (!load_strobe_pin_n_i[*6] |-> transfer_o)
        else $error("pin ignored");
    ack_edge_a: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("ack edge");
    ack_hold_a: assert property ($rose(scl_i) && !sda_oe_o |-> ##1 !sda_oe_o[*5])
        else $error("ack short");
    ack_len_a: assert property ($fell(sda_oe_o) |-> !sda_oe_o[*8] ##[1:8] sda_oe_o)
        else $error("ack length");
    reset_quiet_a: assert property ($past(rst_i) |-> !transfer_o && $stable(dac_code_o))
        else $error("reset not quiet");
endmodule // dbu_checker
bind dbu_top dbu_checker #(.DEV_ADDR(DEV_ADDR)) dbu_checker_inst (
    .clock_i(clock_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_oe_o(sda_oe_o), .load_strobe_pin_n_i(load_strobe_pin_n_i),
    .dac_code_o(dac_code_o), .transfer_o(transfer_o));
`default_nettype wire

// ---- dbu_host_model.sv ----
`default_nettype none
// ****
// serial host
// ****
module dbu_host_model (
    output var logic scl_o,
    output var logic sda_o,
    input wire logic sda_i
);
    timeunit 1ns;
    timeprecision 10ps;
    localparam realtime Q = 31.25;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // one link clock: data set while low, sampled while high
    task automatic sq(input logic [2:0] d, output logic s);
        scl_o = 1'b0;
        #Q;
        sda_o = d[2];
        #Q;
        scl_o = 1'b1;
        sda_o = d[1];
        #Q;
        s = sda_i;
        sda_o = d[0];
        #Q;
    endtask
    task automatic frame(input logic st);
        logic s;
        sq(st ? 3'b110 : 3'b001, s);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            sq({3{b[i]}}, s);
        end
        sq(3'b111, s);
        ack = !s;
    endtask
endmodule // dbu_host_model
`default_nettype wire

// ---- dbu_link_rx.sv ----
`default_nettype none
module dbu_link_rx
    import dbu_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    dbu_byte_if.rx link
);
    // ****************************************************************
    // pin synchronisers and edge history
    // ****************************************************************
    logic scl_m, scl_q, scl_d, sda_m, sda_q, sda_d;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            scl_m <= 1'b1;
            scl_q <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_q <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= scl_i;
            scl_q <= scl_m;
            scl_d <= scl_q;
            sda_m <= sda_i;
            sda_q <= sda_m;
            sda_d <= sda_q;
        end
    end

    logic scl_rise, scl_fall, start_seen, stop_seen;
    assign scl_rise = scl_q & ~scl_d;
    assign scl_fall = ~scl_q & scl_d;
    assign start_seen = scl_q & scl_d & sda_d & ~sda_q;
    assign stop_seen = scl_q & scl_d & ~sda_d & sda_q;

    // ****************************************************************
    // bit shifter and acknowledge drive
    // ****************************************************************
    logic [3:0] cnt, next_cnt;
    logic [7:0] shift, next_shift;
    logic drive, next_drive;
    logic valid, next_valid;
    always_comb begin
        next_cnt = cnt;
        next_shift = shift;
        next_drive = drive;
        next_valid = 1'b0;
        if (start_seen || stop_seen) begin
            next_cnt = CNT_ZERO;
            next_drive = 1'b0;
        end else if (scl_rise && cnt <= CNT_LAST_BIT) begin
            next_shift = {shift[6:0], sda_q};
            next_cnt = cnt + CNT_STEP;
            next_valid = (cnt == CNT_LAST_BIT);
        end else if (scl_fall && cnt == CNT_ACK) begin
            next_drive = link.ack;
            next_cnt = CNT_ACK_HOLD;
        end else if (scl_fall && cnt == CNT_ACK_HOLD) begin
            next_drive = 1'b0;
            next_cnt = CNT_ZERO;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= CNT_ZERO;
            shift <= 8'h00;
            drive <= 1'b0;
            valid <= 1'b0;
        end else begin
            cnt <= next_cnt;
            shift <= next_shift;
            drive <= next_drive;
            valid <= next_valid;
        end
    end

    assign link.start = start_seen;
    assign link.stop = stop_seen;
    assign link.byte_valid = valid;
    assign link.byte_data = shift;
    assign sda_o = 1'b0;
    assign sda_oe_o = ~drive;
endmodule // dbu_link_rx
`default_nettype wire

// ---- dbu_pkg.sv ----
`default_nettype none
// ****************************************************************
// shared constants
// ****************************************************************
package dbu_pkg;
    localparam int CH_COUNT = 20;
    localparam int CODE_W = 10;
    localparam int ADDR_W = 5;
    localparam logic [9:0] MIDSCALE = 10'h200;
    localparam logic [4:0] ADDR_LAST = 5'h13;
    localparam logic [4:0] ADDR_STEP = 5'h01;
    localparam logic [2:0] ADDR_PAD = 3'h0;
    localparam int CMD_BIT = 7;
    localparam int MSB_HI = 1;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_STEP = 4'h1;
    localparam logic [3:0] CNT_LAST_BIT = 4'h7;
    localparam logic [3:0] CNT_ACK = 4'h8;
    localparam logic [3:0] CNT_ACK_HOLD = 4'h9;
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_DEV = 6'h02,
        ST_DAC = 6'h04,
        ST_MSB = 6'h08,
        ST_LSB = 6'h10,
        ST_SKIP = 6'h20
    } dbu_state_e;
endpackage
`default_nettype wire

// ---- dbu_top.sv ----
`default_nettype none
// Function
// - a new code written over the link with bit 15 zero lands only in the channel's holding register, outputs unchanged.
// - the load strobe pin copies every holding register into the active outputs.
// - a data write whose bit 15 is one acts as a software transfer of all channels.
// - that software transfer happens when the last data bit of the commanding write arrives.
// - at reset every holding and active code is midscale.
// - each code arrives as two bytes, upper first, bits 9..8 from the upper byte's low bits.
// - a holding register is written only after both bytes, then the address steps to the next channel; after channel 19 further bytes are ignored.
// - only channel address bytes with upper three bits zero and address 0 to 19 are acknowledged.
module dbu_top
    import dbu_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT // arbitrary value
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic load_strobe_pin_n_i,
    output logic [CH_COUNT*CODE_W-1:0] dac_code_o,
    output logic transfer_o
);
    // ****************************************************************
    // link receiver
    // ****************************************************************
    dbu_byte_if link ();

    dbu_link_rx u_rx (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .link(link)
    );

    // ****************************************************************
    // load strobe synchroniser
    // ****************************************************************
    logic ld_m, ld_q;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ld_m <= 1'b1;
            ld_q <= 1'b1;
        end else begin
            ld_m <= load_strobe_pin_n_i;
            ld_q <= ld_m;
        end
    end

    // ****************************************************************
    // write sequencer
    // ****************************************************************
    dbu_state_e state, next_state;
    logic [ADDR_W-1:0] ptr, next_ptr;
    logic [1:0] upper, next_upper;
    logic cmd, next_cmd;
    logic ack, next_ack;
    logic wr_en;
    logic sw_load;
    logic [CODE_W-1:0] wr_code;

    // ****************************************************************
    // byte decode
    // ****************************************************************
    logic dev_match;
    logic chan_ok;
    assign dev_match = (link.byte_data[7:1] == DEV_ADDR) && !link.byte_data[0];
    assign chan_ok = (link.byte_data[7:5] == ADDR_PAD) && (link.byte_data[4:0] <= ADDR_LAST);

    always_comb begin
        next_state = state;
        next_ptr = ptr;
        next_upper = upper;
        next_cmd = cmd;
        next_ack = ack;
        wr_en = 1'b0;
        sw_load = 1'b0;
        wr_code = {upper, link.byte_data};
        if (link.start) begin
            next_state = ST_DEV;
            next_ack = 1'b0;
        end else if (link.stop) begin
            next_state = ST_IDLE;
            next_ack = 1'b0;
        end else if (link.byte_valid) begin
            next_ack = 1'b0;
            case (state)
                ST_DEV: begin
                    if (dev_match) begin
                        next_state = ST_DAC;
                        next_ack = 1'b1;
                    end else begin
                        next_state = ST_SKIP;
                    end
                end
                ST_DAC: begin
                    if (chan_ok) begin
                        next_ptr = link.byte_data[4:0];
                        next_state = ST_MSB;
                        next_ack = 1'b1;
                    end else begin
                        next_state = ST_SKIP;
                    end
                end
                ST_MSB: begin
                    next_upper = link.byte_data[MSB_HI:0];
                    next_cmd = link.byte_data[CMD_BIT];
                    next_state = ST_LSB;
                    next_ack = 1'b1;
                end
                ST_LSB: begin
                    wr_en = 1'b1;
                    sw_load = cmd;
                    next_ack = 1'b1;
                    if (ptr == ADDR_LAST) begin
                        next_state = ST_SKIP;
                    end else begin
                        next_ptr = ptr + ADDR_STEP;
                        next_state = ST_MSB;
                    end
                end
                ST_IDLE: begin
                    next_state = ST_IDLE;
                end
                ST_SKIP: begin
                    next_state = ST_SKIP;
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // sequencer registers
    // ****************************************************************
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            ptr <= '0;
            upper <= 2'h0;
            cmd <= 1'b0;
            ack <= 1'b0;
        end else begin
            state <= next_state;
            ptr <= next_ptr;
            upper <= next_upper;
            cmd <= next_cmd;
            ack <= next_ack;
        end
    end

    // ****************************************************************
    // link acknowledge
    // ****************************************************************
    assign link.ack = ack;

    // ****************************************************************
    // holding and active register banks
    // ****************************************************************
    // ****************************************************************
    // transfer decision
    // ****************************************************************
    logic pin_load;
    logic load_all;
    logic next_transfer;
    always_comb begin
        pin_load = ~ld_q;
        load_all = sw_load | pin_load;
        next_transfer = load_all;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            transfer_o <= 1'b0;
        end else begin
            transfer_o <= next_transfer;
        end
    end

    logic [CODE_W-1:0] hold [CH_COUNT];
    logic [CODE_W-1:0] next_hold [CH_COUNT];
    logic [CODE_W-1:0] active [CH_COUNT];
    logic [CODE_W-1:0] next_active [CH_COUNT];

    // ****************************************************************
    // per channel next values and outputs
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < CH_COUNT; g++) begin : g_ch
            assign next_hold[g] = (wr_en && ptr == ADDR_W'(g)) ? wr_code : hold[g];
            assign next_active[g] = load_all ? next_hold[g] : active[g];
            assign dac_code_o[g*CODE_W +: CODE_W] = active[g];
        end
    endgenerate

    // ****************************************************************
    // bank registers
    // ****************************************************************
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < CH_COUNT; i++) begin
                hold[i] <= MIDSCALE;
                active[i] <= MIDSCALE;
            end
        end else begin
            for (int i = 0; i < CH_COUNT; i++) begin
                hold[i] <= next_hold[i];
                active[i] <= next_active[i];
            end
        end
    end
endmodule // dbu_top
`default_nettype wire

// ---- test_dac_double_buffer_update.sv ----
`default_nettype none
// ****
// bench
// ****
module test_dac_double_buffer_update
    import dbu_pkg::*;
();
    timeunit 1ns;
    timeprecision 10ps;
    localparam logic [6:0] DA = 7'h35; // arbitrary value
    localparam logic [CH_COUNT*CODE_W-1:0] MID = {CH_COUNT{MIDSCALE}};
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic ld_n = 1'b1;
    logic ack;
    wire logic scl;
    wire logic host_sda;
    wire logic sda_w;
    logic sda_o;
    logic sda_oe_o;
    logic transfer_o;
    logic [CH_COUNT*CODE_W-1:0] dac, expv;
    logic [7:0] bad [3] = '{8'h14, 8'h20, 8'hff};
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;
    assign sda_w = host_sda & (sda_oe_o | sda_o);
    dbu_top #(.DEV_ADDR(DA)) dbu_top_inst (
        .clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .load_strobe_pin_n_i(ld_n), .dac_code_o(dac), .transfer_o(transfer_o));
    dbu_host_model dbu_host_model_inst (.scl_o(scl), .sda_o(host_sda), .sda_i(sda_w));
    initial begin
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic put(input logic [7:0] b, input logic e);
        dbu_host_model_inst.wbyte(b, ack);
        chk(ack === e, "ack");
    endtask
    task automatic hdr();
        dbu_host_model_inst.frame(1'b1);
        put({DA, 1'b0}, 1'b1);
    endtask
    task automatic t_reset();
        @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        #1;
        chk(dac === MID && transfer_o === 1'b0, "reset");
        expv = MID;
        $display("test reset done");
    endtask
    task automatic t_preload();
        hdr();
        put(8'h00, 1'b1);
        put(8'h7d, 1'b1);
        put(8'h55, 1'b1);
        put(8'h03, 1'b1);
        put(8'hff, 1'b1);
        put(8'h02, 1'b1);
        dbu_host_model_inst.frame(1'b0);
        chk(dac === MID, "preload moved");
        @(posedge clock_i);
        ld_n <= 1'b0;
        repeat (8) @(posedge clock_i);
        ld_n <= 1'b1;
        repeat (6) @(posedge clock_i);
        #1;
        expv[9:0] = 10'h155;
        expv[19:10] = 10'h3ff;
        chk(dac === expv, "load pin");
        $display("test preload done");
    endtask
    task automatic t_soft();
        hdr();
        put(8'h12, 1'b1);
        put(8'h02, 1'b1);
        put(8'h34, 1'b1);
        put(8'h81, 1'b1);
        chk(dac === expv, "early");
        put(8'h0f, 1'b1);
        expv[189:180] = 10'h234;
        expv[199:190] = 10'h10f;
        chk(dac === expv, "soft");
        put(8'h00, 1'b0);
        dbu_host_model_inst.frame(1'b0);
        $display("test soft done");
    endtask
    task automatic t_refuse();
        foreach (bad[i]) begin
            hdr();
            put(bad[i], 1'b0);
            put(8'h81, 1'b0);
        end
        dbu_host_model_inst.frame(1'b1);
        put({DA, 1'b1}, 1'b0);
        dbu_host_model_inst.frame(1'b1);
        put({DA ^ 7'h01, 1'b0}, 1'b0);
        dbu_host_model_inst.frame(1'b0);
        chk(dac === expv, "refused moved");
        $display("test refuse done");
    endtask
    task automatic results();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        t_reset();
        t_preload();
        t_soft();
        t_refuse();
        t_reset();
        results();
    end
endmodule // test_dac_double_buffer_update
`default_nettype wire
